// ===== bench/slvp_ext_cpu.sv
`timescale 1ns/1ps
module slvp_ext_cpu (
  // clock
  input wire logic ref_clk,
  // strobes and data bus
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data = 8'h00;
  end
  // no pull-ups: a released bus shows the inverse of its last value
  task automatic access(input logic wr, input logic [7:0] b, input int n);
    @(posedge ref_clk);
    data <= wr ? b : ~data;
    cs_n <= 1'b0;
    wr_n <= ~wr;
    rd_n <= wr;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic leave(input int n);
    @(posedge ref_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // data held one cycle past the strobe rise
    @(posedge ref_clk);
    data <= ~data;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule

// ===== bench/slvp_top_assertions.sv
`timescale 1ns/1ps
module slvp_top_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // wishbone
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [4:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic wb_ack,
  // pins
  input wire logic [7:0] data_pin_out,
  input wire logic data_pin_oe,
  input wire logic control_pin_0,
  input wire logic control_pin_1,
  input wire logic control_pin_2,
  input wire logic capture_pwm_unit_multi_out
);
  logic sw_wr;
  assign sw_wr = wb_cyc && wb_stb && wb_we && !wb_ack && wb_adr[4:2] == 3'h0 && wb_sel[0];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  chk_rd_start: assert property ($rose(data_pin_oe) |->
    !control_pin_0 && !control_pin_2 && control_pin_1 && !$past(control_pin_0, 3))
    else $error("drive without read strobes");
  // the read state and the enable are set on the same edge, decided in the cycle before, so the veto is one back
  chk_rd_gated: assert property ($rose(data_pin_oe) |->
    !$past(capture_pwm_unit_multi_out)) else $error("drive while pwm blocks port");
  chk_rd_release: assert property ($rose(control_pin_0) && data_pin_oe |->
    ##[1:8] !data_pin_oe) else $error("bus not released");
  chk_oe_cause: assert property ($fell(data_pin_oe) |->
    control_pin_0 || control_pin_2 || capture_pwm_unit_multi_out) else $error("early release");
  chk_rd_fresh: assert property (data_pin_oe && sw_wr |=>
    data_pin_out == $past(wb_dat_w[7:0])) else $error("new latch not driven");
  chk_rd_steady: assert property (data_pin_oe && $past(data_pin_oe) && !$past(sw_wr) |->
    $stable(data_pin_out)) else $error("driven byte changed");
endmodule

// ===== bench/tb_slvp_top.sv
`timescale 1ns/1ps
`include "slvp_map.svh"
module tb_slvp_top;
  logic ref_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, oe, irq, pwm, cs_n, rd_n, wr_n;
  logic [4:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  logic [7:0] din, dout, b;
  int fails, checked, m_mode, m_ibf, m_obf, m_input_overflow, m_stat;
  int in_q[$];

  slvp_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .data_pin_in(din), .data_pin_out(dout), .data_pin_oe(oe),
    .control_pin_0(rd_n), .control_pin_1(wr_n), .control_pin_2(cs_n),
    .capture_pwm_unit_multi_out(pwm), .irq(irq));
  slvp_ext_cpu u_cpu (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data(din));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp_reg({24'h00_0000, got}, {24'h00_0000, exp});
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [4:0] a, input int e);
    wb(1'b0, a, 8'h00);
    cmp_reg(q, 32'(e));
  endtask
  function automatic int ectl();
    return m_ibf * 128 + m_obf * 64 + m_input_overflow * 32 + m_mode * 16 + 7;
  endfunction
  // model update follows the access only when the port is live
  task automatic ext_wr(input logic [7:0] v, input int n);
    u_cpu.access(1'b1, v, n);
    u_cpu.leave(8);
    if (m_mode == 1 && pwm == 1'b0) begin
      in_q.push_back(v);
      m_stat = m_stat | 1 | (m_ibf * 2);
      m_input_overflow = m_input_overflow | m_ibf;
      m_ibf = 1;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 5'h00;
    wb_sel = 4'hF;
    wb_dat_w = 32'h0000_0000;
    pwm = 1'b0;
    void'($urandom(40619));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`SLVP_OFF_CTRL, ectl());
    rd(`SLVP_OFF_DATA, 0);
    wb(1'b1, 5'h14, 8'hFF);
    rd(5'h14, 0);
    b = 8'h0A + 8'($urandom_range(5));
    wb(1'b1, `SLVP_OFF_ANCFG, b);
    rd(`SLVP_OFF_ANCFG, b);
    wb(1'b1, `SLVP_OFF_CTRL, 8'h17);
    m_mode = 1;
    wb(1'b1, `SLVP_OFF_IRQ_MASK, 8'h03);
    rd(`SLVP_OFF_CTRL, ectl());
    $display("test setup done");
    for (int i = 0; i < 2; i++) begin
      ext_wr(8'($urandom), 5 + i * 6);
      for (int n = 0; n < 50 && irq !== 1'b1; n++) @(posedge ref_clk);
      cmp_pin({7'h00, irq}, 8'h01);
      rd(`SLVP_OFF_CTRL, ectl());
    end
    rd(`SLVP_OFF_IRQ_STAT, m_stat);
    rd(`SLVP_OFF_DATA, in_q[$]);
    m_ibf = 0;
    wb(1'b1, `SLVP_OFF_CTRL, 8'h17);
    m_input_overflow = 0;
    rd(`SLVP_OFF_CTRL, ectl());
    wb(1'b1, `SLVP_OFF_IRQ_STAT, 8'h03);
    m_stat = 0;
    $display("test external writes done");
    // a write without byte lane 0 is acked but must leave the latch and its flag alone
    wb_sel <= 4'hE;
    wb(1'b1, `SLVP_OFF_DATA, 8'h5A);
    wb_sel <= 4'hF;
    rd(`SLVP_OFF_CTRL, ectl());
    b = 8'($urandom);
    wb(1'b1, `SLVP_OFF_DATA, b);
    m_obf = 1;
    rd(`SLVP_OFF_CTRL, ectl());
    u_cpu.access(1'b0, 8'h00, 8);
    cmp_pin(dout, b);
    cmp_pin({7'h00, oe}, 8'h01);
    m_obf = 0;
    rd(`SLVP_OFF_CTRL, ectl());
    b = 8'($urandom);
    wb(1'b1, `SLVP_OFF_DATA, b);
    @(posedge ref_clk);
    cmp_pin(dout, b);
    rd(`SLVP_OFF_CTRL, ectl());
    u_cpu.leave(8);
    cmp_pin({7'h00, oe}, 8'h00);
    m_stat = 1;
    rd(`SLVP_OFF_IRQ_STAT, m_stat);
    wb(1'b1, `SLVP_OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge ref_clk);
    cmp_pin({7'h00, irq}, 8'h00);
    wb(1'b1, `SLVP_OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    cmp_pin({7'h00, irq}, 8'h01);
    wb(1'b1, `SLVP_OFF_IRQ_STAT, 8'h01);
    m_stat = 0;
    repeat (2) @(posedge ref_clk);
    cmp_pin({7'h00, irq}, 8'h00);
    $display("test external read done");
    pwm <= 1'b1;
    ext_wr(8'($urandom), 6);
    u_cpu.access(1'b0, 8'h00, 8);
    cmp_pin({7'h00, oe}, 8'h00);
    u_cpu.leave(8);
    pwm <= 1'b0;
    wb(1'b1, `SLVP_OFF_CTRL, 8'h07);
    m_mode = 0;
    ext_wr(8'($urandom), 6);
    rd(`SLVP_OFF_CTRL, ectl());
    rd(`SLVP_OFF_IRQ_STAT, m_stat);
    $display("test blocked port done");
    give_verdict();
  end
endmodule

bind slvp_top slvp_top_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
  .wb_dat_w(wb_dat_w), .wb_ack(wb_ack), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe), .control_pin_0(control_pin_0), .control_pin_1(control_pin_1),
  .control_pin_2(control_pin_2), .capture_pwm_unit_multi_out(capture_pwm_unit_multi_out));

// ===== rtl/slvp_map.svh
`ifndef SLVP_MAP_SVH
`define SLVP_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SLVP_OFF_DATA 5'h00
`define SLVP_OFF_CTRL 5'h04
`define SLVP_OFF_ANCFG 5'h08
`define SLVP_OFF_IRQ_STAT 5'h0C
`define SLVP_OFF_IRQ_MASK 5'h10

// ----------------------------------------
// control/status field positions
// ----------------------------------------
`define SLVP_CTRL_IBF 7
`define SLVP_CTRL_OBF 6
`define SLVP_CTRL_INPUT_OVERFLOW 5
`define SLVP_CTRL_MODE 4
`define SLVP_CTRL_DIR_HI 2
`define SLVP_ANCFG_HI 5

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define SLVP_NUM_EVT 2
`define SLVP_EVT_DONE 0
`define SLVP_EVT_OVF 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLVP_DIR_RST 3'h7
`define SLVP_ANCFG_RST 6'h00
`define SLVP_BYTE_RST 8'h00
`define SLVP_EVT_RST 2'h0
`define SLVP_SYNC_RST 11'h007

`endif

// ===== rtl/slvp_pkg.sv
package slvp_pkg;

  typedef enum logic [1:0] {
    SLVP_IDLE,
    SLVP_WRITE,
    SLVP_READ
  } slvp_state_t;

  typedef logic [7:0] slvp_byte_t;

endpackage

// ===== rtl/slvp_strobe_if.sv
`timescale 1ns/1ps
interface slvp_strobe_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] data;
  modport src (output cs_n, output rd_n, output wr_n, output data);
  modport dst (input cs_n, input rd_n, input wr_n, input data);
endinterface

// ===== rtl/slvp_sync.sv
`timescale 1ns/1ps
`include "slvp_map.svh"

module slvp_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // raw pins: data, control_pin_2, control_pin_1, control_pin_0
  input wire logic [10:0] raw,
  // filtered levels
  slvp_strobe_if.src lvl
);

  localparam logic [10:0] SYNC_RST = `SLVP_SYNC_RST;

  logic [10:0] s1_r;
  logic [10:0] s2_r;
  logic [10:0] s3_r;
  logic [10:0] lvl_r;

  // ----------------------------------------
  // three stages, change accepted when two and three agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 11; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          s1_r[i] <= SYNC_RST[i];
          s2_r[i] <= SYNC_RST[i];
          s3_r[i] <= SYNC_RST[i];
          lvl_r[i] <= SYNC_RST[i];
        end else begin
          s1_r[i] <= raw[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            lvl_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign lvl.rd_n = lvl_r[0];
  assign lvl.wr_n = lvl_r[1];
  assign lvl.cs_n = lvl_r[2];
  assign lvl.data = lvl_r[10:3];

endmodule

// ===== rtl/slvp_top.sv
`timescale 1ns/1ps
`include "slvp_map.svh"

// Contract
// - the slave port works only while the mode bit is set and the pwm unit is not in multi-output mode.
// - the external processor reads the eight-bit output latch and writes a separate eight-bit input latch.
// - in slave mode control pin 0 is read, pin 1 is write and pin 2 is chip select, all low active.
// - an external write starts when select and write are first seen low and ends when either is high.
// - the end of an external write sets the port event flag and input-buffer-full.
// - a read start drives the output latch on the data pins and clears output-buffer-full.
// - a software write during an external read goes out at once and leaves output-buffer-full clear.
// - a read end releases the data pins and sets the port event flag.
// - an external write while the last word is unread sets input overflow until software clears it.
// - output-buffer-full is set while a software word awaits the external reader.
module slvp_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [4:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // external processor pins
  input wire logic [7:0] data_pin_in,
  output logic [7:0] data_pin_out,
  output logic data_pin_oe,
  input wire logic control_pin_0,
  input wire logic control_pin_1,
  input wire logic control_pin_2,
  // pwm unit status
  input wire logic capture_pwm_unit_multi_out,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  slvp_pkg::slvp_state_t state_r;
  slvp_pkg::slvp_state_t state_nxt;
  logic mode_r;
  logic [2:0] dir_r;
  logic [5:0] ancfg_r;
  slvp_pkg::slvp_byte_t out_latch_r;
  slvp_pkg::slvp_byte_t out_latch_nxt;
  slvp_pkg::slvp_byte_t in_latch_r;
  slvp_pkg::slvp_byte_t in_shadow_r;
  logic ibf_r;
  logic ibf_nxt;
  logic obf_r;
  logic obf_nxt;
  logic input_overflow_r;
  logic input_overflow_nxt;
  logic [`SLVP_NUM_EVT-1:0] evt_stat_r;
  logic [`SLVP_NUM_EVT-1:0] evt_stat_nxt;
  logic [`SLVP_NUM_EVT-1:0] evt_mask_r;
  logic [`SLVP_NUM_EVT-1:0] evt;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  slvp_pkg::slvp_byte_t data_out_r;
  logic oe_r;
  logic irq_r;
  logic wr_end;
  logic rd_start;
  logic rd_end;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  slvp_strobe_if strb ();

  slvp_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .raw({data_pin_in, control_pin_2, control_pin_1, control_pin_0}),
    .lvl(strb)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [4:0] adr, input logic [4:0] off);
    return adr[4:2] == off[4:2];
  endfunction

  wire req = wb_cyc & wb_stb & ~ack_r;
  // writes need lane 0; the upper lanes hold nothing
  wire wr_req = req & wb_we & wb_sel[0];
  wire rd_req = req & ~wb_we;
  wire hit_data = reg_hit(wb_adr, `SLVP_OFF_DATA);
  wire hit_ctrl = reg_hit(wb_adr, `SLVP_OFF_CTRL);
  wire hit_ancfg = reg_hit(wb_adr, `SLVP_OFF_ANCFG);
  wire hit_stat = reg_hit(wb_adr, `SLVP_OFF_IRQ_STAT);
  wire hit_mask = reg_hit(wb_adr, `SLVP_OFF_IRQ_MASK);
  wire sw_wr_data = wr_req & hit_data;
  wire sw_rd_data = rd_req & hit_data;
  wire sw_wr_ctrl = wr_req & hit_ctrl;
  wire sw_wr_ancfg = wr_req & hit_ancfg;
  wire sw_wr_stat = wr_req & hit_stat;
  wire sw_wr_mask = wr_req & hit_mask;

  // ----------------------------------------
  // access detection
  // ----------------------------------------
  // multi-output pwm borrows the port pins, so it vetoes the mode
  wire active = mode_r & ~capture_pwm_unit_multi_out;
  wire ext_wr = active & ~strb.cs_n & ~strb.wr_n;
  wire ext_rd = active & ~strb.cs_n & ~strb.rd_n;

  always_comb begin
    state_nxt = state_r;
    wr_end = 1'b0;
    rd_start = 1'b0;
    rd_end = 1'b0;
    case (state_r)
      slvp_pkg::SLVP_IDLE: begin
        if (ext_wr) begin
          state_nxt = slvp_pkg::SLVP_WRITE;
        end else if (ext_rd) begin
          state_nxt = slvp_pkg::SLVP_READ;
          rd_start = 1'b1;
        end
      end
      slvp_pkg::SLVP_WRITE: begin
        if (!ext_wr) begin
          state_nxt = slvp_pkg::SLVP_IDLE;
          wr_end = 1'b1;
        end
      end
      slvp_pkg::SLVP_READ: begin
        if (!ext_rd) begin
          state_nxt = slvp_pkg::SLVP_IDLE;
          rd_end = 1'b1;
        end
      end
      default: begin
        state_nxt = slvp_pkg::SLVP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= slvp_pkg::SLVP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // data latches
  // ----------------------------------------
  // the bus byte is followed while the strobe is low; the last value wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_shadow_r <= `SLVP_BYTE_RST;
      in_latch_r <= `SLVP_BYTE_RST;
    end else begin
      if (ext_wr) begin
        in_shadow_r <= strb.data;
      end
      if (wr_end) begin
        in_latch_r <= in_shadow_r;
      end
    end
  end

  assign out_latch_nxt = sw_wr_data ? wb_dat_w[7:0] : out_latch_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_latch_r <= `SLVP_BYTE_RST;
    end else begin
      out_latch_r <= out_latch_nxt;
    end
  end

  // ----------------------------------------
  // buffer status
  // ----------------------------------------
  // hardware set wins over a software clear in the same cycle
  assign ibf_nxt = wr_end | (ibf_r & ~sw_rd_data);
  assign evt[`SLVP_EVT_OVF] = wr_end & ibf_r;
  assign input_overflow_nxt = evt[`SLVP_EVT_OVF] |
                    (input_overflow_r & ~(sw_wr_ctrl & ~wb_dat_w[`SLVP_CTRL_INPUT_OVERFLOW]));
  assign evt[`SLVP_EVT_DONE] = wr_end | rd_end;

  always_comb begin
    obf_nxt = obf_r;
    if (rd_start) begin
      obf_nxt = 1'b0;
    end else if (sw_wr_data && state_r != slvp_pkg::SLVP_READ) begin
      obf_nxt = 1'b1;
    end else if (sw_wr_data) begin
      obf_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ibf_r <= 1'b0;
      obf_r <= 1'b0;
      input_overflow_r <= 1'b0;
    end else begin
      ibf_r <= ibf_nxt;
      obf_r <= obf_nxt;
      input_overflow_r <= input_overflow_nxt;
    end
  end

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  // direction and analog fields are storage only; software owns them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_r <= 1'b0;
      dir_r <= `SLVP_DIR_RST;
      ancfg_r <= `SLVP_ANCFG_RST;
    end else begin
      if (sw_wr_ctrl) begin
        mode_r <= wb_dat_w[`SLVP_CTRL_MODE];
        dir_r <= wb_dat_w[`SLVP_CTRL_DIR_HI:0];
      end
      if (sw_wr_ancfg) begin
        ancfg_r <= wb_dat_w[`SLVP_ANCFG_HI:0];
      end
    end
  end

  // ----------------------------------------
  // data pin drive
  // ----------------------------------------
  // next latch value is driven, so a write during a read goes straight out
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_out_r <= `SLVP_BYTE_RST;
      oe_r <= 1'b0;
    end else begin
      data_out_r <= out_latch_nxt;
      oe_r <= (state_nxt == slvp_pkg::SLVP_READ);
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SLVP_NUM_EVT; gi++) begin : g_evt
      assign evt_stat_nxt[gi] = evt[gi] | (evt_stat_r[gi] & ~(sw_wr_stat & wb_dat_w[gi]));
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      evt_stat_r <= `SLVP_EVT_RST;
      evt_mask_r <= `SLVP_EVT_RST;
      irq_r <= 1'b0;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      if (sw_wr_mask) begin
        evt_mask_r <= wb_dat_w[`SLVP_NUM_EVT-1:0];
      end
      irq_r <= |(evt_stat_r & evt_mask_r);
    end
  end

  // ----------------------------------------
  // read data and acknowledge
  // ----------------------------------------
  wire [7:0] ctrl_word = {ibf_r, obf_r, input_overflow_r, mode_r, 1'b0, dir_r};

  assign rdat_nxt = hit_data ? {24'h00_0000, in_latch_r} :
                    hit_ctrl ? {24'h00_0000, ctrl_word} :
                    hit_ancfg ? {26'h000_0000, ancfg_r} :
                    hit_stat ? {30'h0000_0000, evt_stat_r} :
                    hit_mask ? {30'h0000_0000, evt_mask_r} :
                    32'h0000_0000;

  // one-cycle answer; unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (rd_req) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack = ack_r;
  assign wb_dat_r = rdat_r;
  assign data_pin_out = data_out_r;
  assign data_pin_oe = oe_r;
  assign irq = irq_r;

endmodule
